/* File: src/pmd_pkg.sv */
// Package for the program memory map decoder: address map, vectors,
// configuration layout and register offsets.
// Assumes a single 10 MHz core clock and an APB register port.
package pmd_pkg;

  localparam int          PMD_ADDR_W       = 21;
  localparam int          PMD_EXT_ADDR_W   = 20;
  localparam logic [20:0] PMD_SPACE_TOP    = 21'h1fffff;
  localparam logic [20:0] PMD_RESET_VEC    = 21'h000000;
  localparam logic [20:0] PMD_HI_VEC       = 21'h000008;
  localparam logic [20:0] PMD_LO_VEC       = 21'h000018;

  // Flash sizes and configuration block bases, per size code
  localparam logic [1:0]  PMD_SIZE_64K     = 2'h0;
  localparam logic [1:0]  PMD_SIZE_96K     = 2'h1;
  localparam logic [1:0]  PMD_SIZE_128K    = 2'h2;
  localparam logic [20:0] PMD_TOP_64K      = 21'h010000;
  localparam logic [20:0] PMD_TOP_96K      = 21'h018000;
  localparam logic [20:0] PMD_TOP_128K     = 21'h020000;
  localparam logic [20:0] PMD_CFG_64K      = 21'h00fff8;
  localparam logic [20:0] PMD_CFG_96K      = 21'h017ff8;
  localparam logic [20:0] PMD_CFG_128K     = 21'h01fff8;
  localparam int          PMD_CFG_BYTES    = 8;
  localparam logic [2:0]  PMD_CFG_BYTE_BUS = 3'h4;
  localparam logic [2:0]  PMD_CFG_LAST     = 3'h7;

  // External bus configuration byte layout
  localparam int          PMD_BIT_WAIT     = 7;
  localparam int          PMD_BIT_WIDTH    = 6;
  localparam int          PMD_BIT_MODE_HI  = 5;
  localparam int          PMD_BIT_MODE_LO  = 4;
  localparam int          PMD_BIT_SHIFT    = 3;
  localparam logic [7:0]  PMD_CFG_IMPL     = 8'hf8;
  localparam logic [7:0]  PMD_CFG_RESET    = 8'hf8;

  localparam logic [1:0]  PMD_MODE_ONCHIP  = 2'h3;
  localparam logic [1:0]  PMD_MODE_EXT12   = 2'h2;
  localparam logic [1:0]  PMD_MODE_EXT16   = 2'h1;
  localparam logic [1:0]  PMD_MODE_EXT20   = 2'h0;

  // Bus control register wait field
  localparam int          PMD_WAIT_HI      = 5;
  localparam int          PMD_WAIT_LO      = 4;

  // APB register byte offsets
  localparam logic [7:0]  PMD_OFS_CFG      = 8'h00;
  localparam logic [7:0]  PMD_OFS_BUSCTL   = 8'h04;
  localparam logic [7:0]  PMD_OFS_STATUS   = 8'h08;
  localparam logic [7:0]  PMD_OFS_ADDR     = 8'h0c;
  localparam logic [7:0]  PMD_BUSCTL_RESET = 8'h00;

  typedef enum logic [1:0] {
    PMD_ST_LOAD = 2'b00,
    PMD_ST_RUN  = 2'b01
  } pmd_state_e;

  function automatic logic [20:0] pmd_top(input logic [1:0] sz);
    unique case (sz)
      PMD_SIZE_96K:  pmd_top = PMD_TOP_96K;
      PMD_SIZE_128K: pmd_top = PMD_TOP_128K;
      default:       pmd_top = PMD_TOP_64K;
    endcase
  endfunction : pmd_top

  function automatic logic [20:0] pmd_cfg_base(input logic [1:0] sz);
    unique case (sz)
      PMD_SIZE_96K:  pmd_cfg_base = PMD_CFG_96K;
      PMD_SIZE_128K: pmd_cfg_base = PMD_CFG_128K;
      default:       pmd_cfg_base = PMD_CFG_64K;
    endcase
  endfunction : pmd_cfg_base

endpackage : pmd_pkg

/* File: src/pmd_decode.sv */
// Program memory map decoder: fetch routing, reset-time configuration
// load, external address shaping and an APB status/control port.
// Assumes flash answers reads in the same cycle (combinational data)
// and the external memory answers through ext_rdata in the same cycle.
module pmd_decode
  import pmd_pkg::*;
(
  input  wire  logic        clk,
  input  wire  logic        rst,
  input  wire  logic        pkg_large,
  input  wire  logic [1:0]  flash_size,
  input  wire  logic        fetch_req,
  input  wire  logic [20:0] fetch_addr,
  input  wire  logic        vec_hi,
  input  wire  logic        vec_lo,
  output logic              fetch_valid,
  output logic [15:0]       fetch_data,
  output logic [20:0]       pc_vector,
  output logic              vec_load,
  output logic              flash_req,
  output logic [20:0]       flash_addr,
  input  wire  logic [7:0]  flash_rdata,
  input  wire  logic [15:0] flash_word,
  output logic              ext_req,
  output logic [19:0]       ext_addr,
  input  wire  logic [15:0] ext_rdata,
  output logic              ext_bus_enable,
  output logic [1:0]        ext_addr_width,
  output logic              ext_wide_data,
  output logic              ext_wait_enable,
  output logic [1:0]        ext_wait_count,
  input  wire  logic        data_req,
  input  wire  logic [11:0] data_addr,
  output logic              ram_req,
  output logic [11:0]       ram_addr,
  output logic              config_done,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);

  pmd_state_e  state_reg;
  logic [2:0]  byte_idx_reg;
  logic [7:0]  cfg_reg;
  logic [7:0]  busctl_reg;
  logic [20:0] last_addr_reg;
  logic [20:0] top;
  logic        ext_mode;
  logic        in_flash;
  logic        in_ext;
  logic [20:0] shifted;
  logic [20:0] ext_full;
  logic        apb_acc;
  logic        apb_hit;

  assign top = pmd_top(flash_size);

  assign ext_mode = pkg_large && state_reg == PMD_ST_RUN &&
                    cfg_reg[PMD_BIT_MODE_HI:PMD_BIT_MODE_LO] !=
                    PMD_MODE_ONCHIP;

  assign in_flash = fetch_addr < top;
  assign in_ext   = !in_flash && ext_mode;

  assign shifted  = fetch_addr - top;
  assign ext_full = cfg_reg[PMD_BIT_SHIFT] ? shifted : fetch_addr;

  // Configuration load sequencer
  // Copy configuration after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= PMD_ST_LOAD;
      byte_idx_reg <= 3'h0;
    end else if (state_reg == PMD_ST_LOAD) begin
      byte_idx_reg <= byte_idx_reg + 3'h1;
      if (byte_idx_reg == PMD_CFG_LAST) begin
        state_reg <= PMD_ST_RUN;
      end
    end
  end

  // Ascending byte order, take byte 4 of bytes 0 to 7
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= PMD_CFG_RESET;
    end else if (state_reg == PMD_ST_LOAD &&
                 byte_idx_reg == PMD_CFG_BYTE_BUS) begin
      cfg_reg <= pkg_large ? (flash_rdata & PMD_CFG_IMPL) : PMD_CFG_RESET;
    end
  end

  // Bus control register, software writable
  always_ff @(posedge clk) begin
    if (rst) begin
      busctl_reg <= PMD_BUSCTL_RESET;
    end else if (apb_acc && pwrite && paddr == PMD_OFS_BUSCTL) begin
      busctl_reg <= pwdata[7:0];
    end
  end

  // Flash port: loader owns it until done
  // Configuration base by size
  always_comb begin
    if (state_reg == PMD_ST_LOAD) begin
      flash_req  = 1'b1;
      flash_addr = pmd_cfg_base(flash_size) + {18'h0, byte_idx_reg};
    end else begin
      flash_req  = fetch_req && in_flash;
      flash_addr = fetch_addr;
    end
  end

  assign ext_req  = fetch_req && in_ext && state_reg == PMD_ST_RUN;
  assign ext_addr = ext_full[PMD_EXT_ADDR_W-1:0];

  assign config_done     = state_reg == PMD_ST_RUN;
  assign ext_bus_enable  = ext_mode;
  assign ext_addr_width  = cfg_reg[PMD_BIT_MODE_HI:PMD_BIT_MODE_LO];
  assign ext_wide_data   = ext_mode && cfg_reg[PMD_BIT_WIDTH];
  assign ext_wait_enable = ext_mode && !cfg_reg[PMD_BIT_WAIT];
  assign ext_wait_count  = ext_wait_enable ?
                           busctl_reg[PMD_WAIT_HI:PMD_WAIT_LO] : 2'h0;

  // Data RAM on its own port
  assign ram_req  = data_req;
  assign ram_addr = data_addr;

  // Fetch result register
  // Unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_valid   <= 1'b0;
      fetch_data    <= 16'h0000;
      last_addr_reg <= PMD_RESET_VEC;
    end else begin
      fetch_valid <= fetch_req && state_reg == PMD_ST_RUN;
      if (fetch_req && state_reg == PMD_ST_RUN) begin
        last_addr_reg <= fetch_addr;
        if (in_flash) begin
          fetch_data <= flash_word;
        end else if (in_ext) begin
          fetch_data <= ext_rdata;
        end else begin
          fetch_data <= 16'h0000;
        end
      end
    end
  end

  // Vector selection, reset first
  // Reset vector
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_vector <= PMD_RESET_VEC;
      vec_load  <= 1'b1;
    end else if (vec_hi) begin
      pc_vector <= PMD_HI_VEC;
      vec_load  <= 1'b1;
    end else if (vec_lo) begin
      pc_vector <= PMD_LO_VEC;
      vec_load  <= 1'b1;
    end else begin
      vec_load  <= 1'b0;
    end
  end

  // APB slave, zero wait
  assign apb_acc = psel && penable;
  assign apb_hit = paddr == PMD_OFS_CFG || paddr == PMD_OFS_BUSCTL ||
                   paddr == PMD_OFS_STATUS || paddr == PMD_OFS_ADDR;
  assign pready  = 1'b1;
  assign pslverr = apb_acc && (!apb_hit ||
                   (pwrite && paddr != PMD_OFS_BUSCTL));

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      PMD_OFS_CFG:    prdata = {24'h0, cfg_reg};
      PMD_OFS_BUSCTL: prdata = {24'h0, busctl_reg};
      PMD_OFS_STATUS: prdata = {26'h0, ext_wait_enable, ext_wide_data,
                                ext_bus_enable, pkg_large, flash_size[1],
                                config_done};
      PMD_OFS_ADDR:   prdata = {11'h0, last_addr_reg};
      default:        prdata = 32'h0000_0000;
    endcase
  end

endmodule : pmd_decode

/* File: sim/pmd_props.sv */
// Port assertions for the program memory map decoder.
// Assumes one clock and a synchronous active-high reset.
module pmd_props
  import pmd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        pkg_large,
  input wire logic [1:0]  flash_size,
  input wire logic        fetch_req,
  input wire logic        vec_hi,
  input wire logic        vec_lo,
  input wire logic [15:0] fetch_data,
  input wire logic [20:0] pc_vector,
  input wire logic        vec_load,
  input wire logic        flash_req,
  input wire logic [20:0] flash_addr,
  input wire logic        ext_req,
  input wire logic        ext_bus_enable,
  input wire logic [1:0]  ext_addr_width,
  input wire logic        config_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> pc_vector == PMD_RESET_VEC && vec_load;
  endproperty
  a_rst: assert property (p_rst) else $error("reset vector");
  property p_hi; vec_hi |=> pc_vector == PMD_HI_VEC && vec_load; endproperty
  a_hi: assert property (p_hi) else $error("high vector");
  property p_lo; vec_lo && !vec_hi |=> pc_vector == PMD_LO_VEC; endproperty
  a_lo: assert property (p_lo) else $error("low vector");
  property p_load;
    $fell(rst) |-> (flash_req && !config_done) [*8] ##1 config_done;
  endproperty
  a_load: assert property (p_load) else $error("load length");
  property p_base; $fell(rst) |-> flash_addr == pmd_cfg_base(flash_size)
    ##7 flash_addr == pmd_cfg_base(flash_size) + 21'h7; endproperty
  a_base: assert property (p_base) else $error("load address");
  property p_nop; fetch_req && config_done && !flash_req && !ext_req
    |=> fetch_data == 16'h0; endproperty
  a_nop: assert property (p_nop) else $error("unmapped data");
  property p_off;
    ext_bus_enable |-> pkg_large && ext_addr_width != PMD_MODE_ONCHIP;
  endproperty
  a_off: assert property (p_off) else $error("bus enable");
  property p_hold; config_done && $past(config_done)
    |-> $stable(ext_addr_width) && $stable(ext_bus_enable); endproperty
  a_hold: assert property (p_hold) else $error("setup changed");
endmodule : pmd_props

bind pmd_decode pmd_props pmd_props_u (.clk, .rst, .pkg_large, .flash_size,
  .fetch_req, .vec_hi, .vec_lo, .fetch_data, .pc_vector, .vec_load,
  .flash_req, .flash_addr, .ext_req, .ext_bus_enable, .ext_addr_width,
  .config_done);

/* File: sim/pmd_mem_model.sv */
// Flash and external memory model, answering in the same cycle.
// Assumes the decoder drives requests; idle data toggles every cycle.
module pmd_mem_model
  import pmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  cfg_byte,
  input  wire logic [1:0]  flash_size,
  input  wire logic        flash_req,
  input  wire logic [20:0] flash_addr,
  input  wire logic        ext_req,
  input  wire logic [19:0] ext_addr,
  output logic      [7:0]  flash_rdata,
  output logic      [15:0] flash_word,
  output logic      [15:0] ext_rdata
);
  logic [15:0] junk_reg = 16'h0f0f;
  always @(posedge clk) junk_reg <= ~junk_reg;
  assign flash_rdata = !flash_req ? junk_reg[7:0] :
    flash_addr == pmd_cfg_base(flash_size) + 21'h4 ? cfg_byte :
    flash_addr[7:0];
  assign flash_word = flash_req ? flash_addr[15:0] ^ 16'h5a5a : junk_reg;
  assign ext_rdata  = ext_req ? ext_addr[15:0] ^ 16'ha5a5 : ~junk_reg;
endmodule : pmd_mem_model

/* File: sim/tb_top.sv */
// Bench: random setups, reset-time load, APB, vectors and fetches.
// Assumes the decoder, checker and memory model compiled first.
module tb_top
  import pmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, pkg_large, fetch_req, vec_hi, vec_lo, data_req;
  logic        psel, penable, pwrite, fetch_valid, vec_load, flash_req;
  logic        ext_req, ext_bus_enable, ext_wide_data, ext_wait_enable;
  logic        ram_req, config_done, pready, pslverr, err;
  logic [1:0]  flash_size, ext_addr_width, ext_wait_count;
  logic [7:0]  paddr, flash_rdata, cfg_byte, w;
  logic [11:0] data_addr, ram_addr;
  logic [15:0] fetch_data, flash_word, ext_rdata;
  logic [19:0] ext_addr;
  logic [20:0] fetch_addr, pc_vector, flash_addr, t, e;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, checks_done;

  pmd_decode dut_u (.clk, .rst, .pkg_large, .flash_size, .fetch_req,
    .fetch_addr, .vec_hi, .vec_lo, .fetch_valid, .fetch_data, .pc_vector,
    .vec_load, .flash_req, .flash_addr, .flash_rdata, .flash_word, .ext_req,
    .ext_addr, .ext_rdata, .ext_bus_enable, .ext_addr_width, .ext_wide_data,
    .ext_wait_enable, .ext_wait_count, .data_req, .data_addr, .ram_req,
    .ram_addr, .config_done, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  pmd_mem_model mem_u (.clk, .cfg_byte, .flash_size, .flash_req,
    .flash_addr, .ext_req, .ext_addr, .flash_rdata, .flash_word, .ext_rdata);

  always #50 clk = ~clk;

  function automatic logic [20:0] top_of(input logic [1:0] s);
    return s == 2'h1 ? PMD_TOP_96K : s == 2'h2 ? PMD_TOP_128K : PMD_TOP_64K;
  endfunction : top_of

  function automatic logic [15:0] exp_data(input logic [20:0] a,
    input logic [19:0] ea, input logic x);
    if (a < t) return a[15:0] ^ 16'h5a5a;
    return x ? ea[15:0] ^ 16'ha5a5 : 16'h0;
  endfunction : exp_data

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(negedge clk);
  endtask : apb

  task automatic fetch(input logic [20:0] a);
    logic        x;
    logic [19:0] ea;
    x  = pkg_large && cfg_byte[5:4] != 2'h3 && a >= t;
    ea = 20'(cfg_byte[3] ? a - t : a);
    @(posedge clk);
    {fetch_req, data_req} <= 2'b11;
    fetch_addr <= a;
    data_addr  <= 12'($urandom);
    @(negedge clk);
    check({ram_req, ram_addr}, {1'b1, data_addr});
    if (x) check(ext_addr, ea);
    @(posedge clk);
    {fetch_req, data_req} <= 2'b00;
    @(negedge clk);
    check(fetch_valid, 1'b1);
    check(fetch_data, exp_data(a, ea, x));
  endtask : fetch

  initial begin
    {clk, fetch_req, vec_hi, vec_lo, data_req, psel, penable, pwrite} = '0;
    {fetch_addr, data_addr, paddr, pwdata, flash_size} = '0;
    {rst, pkg_large, cfg_byte} = 10'h3f8;
    {n_errors, checks_done} = '0;
    void'($urandom(61));
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      rst        <= 1'b1;
      pkg_large  <= k < 4 || 1'($urandom);
      flash_size <= 2'(k % 3);
      cfg_byte   <= k < 4 ? {2'($urandom), 2'(k), 4'($urandom)} : 8'($urandom);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t = top_of(flash_size);
      for (int i = 0; i < 8; i++) begin
        e = t - 21'h8 + 21'(i);
        @(negedge clk);
        check({config_done, flash_req, flash_addr}, {2'b01, e});
        if (i == 0) check({vec_load, pc_vector}, {1'b1, 21'h0});
        @(posedge clk);
      end
      @(negedge clk);
      check(config_done, 1'b1);
      w = {3'h0, cfg_byte[5:4] != 2'h3, cfg_byte[5:4],
           cfg_byte[5:4] != 2'h3 && cfg_byte[6],
           cfg_byte[5:4] != 2'h3 && !cfg_byte[7]};
      rd = {ext_bus_enable, ext_addr_width, ext_wide_data, ext_wait_enable};
      if (pkg_large) check(rd, w);
      else check(ext_bus_enable, 1'b0);
      w = 8'($urandom);
      apb(1'b1, PMD_OFS_BUSCTL, {24'h0, w});
      check(ext_wait_count, (pkg_large && !cfg_byte[7] &&
            cfg_byte[5:4] != 2'h3) ? w[5:4] : 2'h0);
      apb(1'b1, PMD_OFS_CFG, 32'hffffffff);
      check(err, 1'b1);
      apb(1'b0, 8'(8'h10 + 4 * k), 32'h0);
      check(err, 1'b1);
      apb(1'b0, PMD_OFS_CFG, 32'h0);
      check(rd[2:0], 3'h0);
      if (pkg_large) check(rd[7:0], cfg_byte & 8'hf8);
      else check(rd[7:0], 8'hf8);
      @(posedge clk);
      vec_hi <= k[0];
      vec_lo <= 1'b1;
      @(posedge clk);
      {vec_hi, vec_lo} <= 2'b00;
      e = k[0] ? PMD_HI_VEC : PMD_LO_VEC;
      @(negedge clk);
      check({vec_load, pc_vector}, {1'b1, e});
      for (int j = 0; j < 6; j++)
        fetch(j == 0 ? t - 21'h2 : j == 1 ? t : j == 2 ? 21'h1ffffe :
              21'($urandom) & 21'h1ffffe);
    end
    final_report;
  end

  // Run needs under 1000 cycles; cut off a hang at 20000
  initial begin
    #2_000_000;
    n_errors++;
    final_report;
  end
endmodule : tb_top
